// >>> verification/oec_properties.sv
// Interface assertions for the amplifier control
`timescale 1ns/1ps
`default_nettype none
module oec_properties (
   input wire logic       i_clk,
   input wire logic       i_reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic [2:0] ev_enable,
   input wire logic [2:0] ev_disable,
   input wire logic [2:0] ev_ready
);
   logic [1:0] ctl_q;
   // Channel 0 mode seen on the bus; a write while frozen updates it though the device keeps its old mode
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) ctl_q <= 2'h0;
      else if (wr && addr == 8'h10) ctl_q <= wdata[1:0];
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ready_pulse_a: assert property ((ev_ready & $past(ev_ready)) == 3'h0)
      else $error("ready too long");
   ready_mode_a: assert property (ev_ready[0] |-> ctl_q == 2'h2)
      else $error("ready outside event mode");
   sel_restart_a: assert property (wr && addr == 8'h13 |=> !ev_ready[0])
      else $error("ready despite restart");
   en_sync_a: assert property ($rose(ev_enable[0]) |-> !ev_ready[0] [*3])
      else $error("enable too early");
   en_ready_a: assert property ($rose(ev_enable[0]) && ctl_q == 2'h2
      |-> ##[3:12] ev_ready[0])
      else $error("no ready after enable");
   dis_off_a: assert property ($rose(ev_disable[0]) && !ev_enable[0]
      |-> ##1 !ev_ready[0] [*4])
      else $error("ready after disable");
   status_rd_a: assert property (rd && addr == 8'h11 |=> rdata[7:1] == 7'h00)
      else $error("status bits");
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not idle");
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Bench joining host and amplifier control through their interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        i_clk = 1'b0, i_reset = 1'b1, cv = 1'b0, wr = 1'b0, rd = 1'b0, sb = 1'b0;
   logic        hl = 1'b0, rv;
   logic [1:0]  ch = 2'h0;
   logic [3:0]  kd = 4'h0;
   logic [7:0]  ag = 8'h00, ad = 8'h00, wd = 8'h00, rdt, lf = 8'h41;
   logic [2:0]  en = 3'h0, ds = 3'h0, dc = 3'h0, dv = 3'h0, rs, amp, den, dsw;
   logic [23:0] isel, lsel, trim;
   int          bad_count = 0, n_tests = 0;
   oec_if bus_if ();
   always #50 i_clk = ~i_clk;
   oec_host oec_host_inst (.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if.host),
      .i_cmd_valid(cv), .i_cmd_kind(kd), .i_cmd_chan(ch), .i_cmd_arg(ag), .i_sw_wr(wr),
      .i_sw_rd(rd), .i_sw_addr(ad), .i_sw_wdata(wd), .i_ev_enable(en), .i_ev_disable(ds),
      .i_ev_discharge(dc), .i_ev_drive(dv), .o_busy(), .o_rd_data(rdt), .o_rd_valid(rv),
      .o_ready_seen(rs));
   oec_device oec_device_inst (.i_clk(i_clk), .i_reset(i_reset), .bus(bus_if.dev),
      .i_standby(sb), .i_cpu_halted(hl), .o_amp_on(amp), .o_drive_en(den),
      .o_discharge_sw(dsw), .o_settle_done_flag(), .o_input_sel(isel), .o_ladder_sel(lsel),
      .o_offset_trim(trim), .o_low_range());
   oec_properties oec_properties_inst (.i_clk(i_clk), .i_reset(i_reset), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
      .ev_enable(bus_if.ev_enable), .ev_disable(bus_if.ev_disable), .ev_ready(bus_if.ev_ready));
   function automatic logic [7:0] nx(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [15:0] cfg(input logic [3:0] k, input logic [2:0] t);
      case (k)
         4'h3: return {2'h0, oec_pkg::NEG_OUT, oec_pkg::POS_PIN, 8'h00};
         4'h4: return 16'h0000;
         4'h5: return {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_PIN,
                       t, oec_pkg::BOT_GND, oec_pkg::TOP_OUT};
         4'h6: return {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_HALF,
                       t, oec_pkg::BOT_NEG_PIN, oec_pkg::TOP_OUT};
         4'h8: return {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_PIN,
                       t, oec_pkg::BOT_NEIGHBOUR, oec_pkg::TOP_OUT};
         default: return {2'h0, oec_pkg::NEG_PIN, oec_pkg::POS_HALF, 8'h00};
      endcase
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      wr <= 1'b1;
      ad <= a;
      wd <= d;
      tick(1);
      wr <= 1'b0;
      tick(3);
   endtask
   // Outputs are sampled at the falling edge so no update race is possible
   task automatic waitr();
      for (int i = 0; i < 20 && rs[0] !== 1'b1; i++) @(negedge i_clk);
      chk({7'h00, rs[0]}, 8'h01);
      tick(1);
   endtask
   task automatic order(input logic [3:0] k, input logic [1:0] c, input logic [7:0] a);
      cv <= 1'b1;
      kd <= k;
      ch <= c;
      ag <= a;
      tick(1);
      cv <= 1'b0;
      tick(4);
   endtask
   task automatic cmd(input logic [3:0] k, input logic [1:0] c, input logic [2:0] t);
      logic [15:0] e;
      int          ci;
      e = cfg(k, t);
      ci = c;
      order(k, c, {5'h00, t});
      tick(2);
      chk(isel[ci*8 +: 8], e[15:8]);
      chk(lsel[ci*8 +: 8], e[7:0]);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      tick(3000);
      bad_count++;
      end_of_test();
   end
   initial begin
      tick(4);
      i_reset <= 1'b0;
      tick(1);
      sw(8'h00, 8'h01);
      for (int i = 0; i < 10; i++) begin
         lf = nx(lf);
         cmd(4'(3+i%6), 2'(lf%3), lf[6:4]);
      end
      sw(8'h10, 8'h02);
      en <= 3'h1;
      waitr();
      rd <= 1'b1;
      ad <= 8'h11;
      tick(1);
      rd <= 1'b0;
      for (int i = 0; i < 6 && rv !== 1'b1; i++) @(negedge i_clk);
      chk(rdt, 8'h01);
      tick(1);
      en <= 3'h0;
      tick(2);
      en <= 3'h1;
      waitr();
      for (int i = 0; i < 8; i++) begin
         lf = nx(lf);
         dv <= lf[2:0];
         dc <= lf[5:3];
         tick(3);
         @(negedge i_clk);
         chk({5'h00, den}, {7'h00, lf[0]});
         chk({5'h00, dsw}, {7'h00, lf[3]});
         tick(1);
      end
      en <= 3'h0;
      dv <= 3'h0;
      dc <= 3'h0;
      tick(2);
      ds <= 3'h1;
      tick(6);
      chk({7'h00, amp[0]}, 8'h00);
      ds <= 3'h0;
      tick(2);
      en <= 3'h1;
      tick(2);
      ds <= 3'h1;
      waitr();
      sb <= 1'b1;
      dv <= 3'h1;
      tick(3);
      chk({6'h00, amp[0], den[0]}, 8'h00);
      sb <= 1'b0;
      sw(8'h10, 8'h82);
      sb <= 1'b1;
      tick(3);
      chk({7'h00, amp[0]}, 8'h01);
      sb <= 1'b0;
      hl <= 1'b1;
      sw(8'h15, 8'h5A);
      chk(trim[7:0], 8'h00);
      sw(8'h01, 8'h01);
      sw(8'h15, 8'hA5);
      chk(trim[7:0], 8'hA5);
      order(4'h9, 2'h0, 8'hFD);
      chk(trim[7:0], 8'hA2);
      order(4'h1, 2'h0, 8'h00);
      chk({7'h00, den[0]}, 8'h01);
      order(4'h2, 2'h0, 8'h00);
      chk({7'h00, den[0]}, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire

// >>> verilog/oec_device.sv
// Amplifier channel control: registers, modes, settle timers, events, sleep and debug
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Events honoured only with event mode enabled
// - Event-driven mode: event enable set, software clear
// - Software-with-events mode: both bits set
// - Ready event is one clock pulse
// - Enable edge async, disable edge sync
// - Drive event forces output driver on
// - Discharge event closes output-to-inverting switch
// - No interrupt; status flag and ready only
// - Standby without run bit shuts channel off
// - Standby shutoff releases pin override
// - Standby with run bit keeps channel running
// - Halted: digital runs only with run-when-halted
// - Trim adjusted by adding the order argument to the shadowed trim
// - Pin-only: pins, ladder off, lowest tap
// - Non-inverting: pin, tap, ground, output
// - Inverting: half supply, tap, negative pin, output
// - Integrator: half supply, negative pin, ladder off
// - Differential: follower plus neighbour-bottom gain stage
// - Settle elapsed sets flag; ready in event-driven mode only
// - Selection register writes restart settle timer
// - Simultaneous enable and disable: enable wins
// - Enable when settle_done_flag: ready issued at once
module oec_device #(
   parameter int NCH = oec_pkg::NCH
) (
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   oec_if.dev                 bus,
   input  wire logic          i_standby,
   input  wire logic          i_cpu_halted,
   output logic [NCH-1:0]     o_amp_on,
   output logic [NCH-1:0]     o_drive_en,
   output logic [NCH-1:0]     o_discharge_sw,
   output logic [NCH-1:0]     o_settle_done_flag,
   output logic [NCH*8-1:0]   o_input_sel,
   output logic [NCH*8-1:0]   o_ladder_sel,
   output logic [NCH*8-1:0]   o_offset_trim,
   output logic               o_low_range
);
   logic       glob_en_q;
   logic       dbg_run_q;
   logic [6:0] timebase_q;
   logic [6:0] us_cnt_q;
   logic       us_tick;
   logic       run;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic [7:0] ctrl_q    [NCH];
   logic [7:0] ladder_q  [NCH];
   logic [7:0] insel_q   [NCH];
   logic [6:0] settle_q  [NCH];
   logic [7:0] trim_q    [NCH];
   logic       settle_done_flag_q [NCH];
   logic       ready_q   [NCH];

   // Digital side freezes when the core is halted unless allowed to run
   assign run = ~i_cpu_halted | dbg_run_q;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         glob_en_q   <= 1'b0;
         dbg_run_q   <= 1'b0;
         timebase_q  <= 7'h00;
         o_low_range <= 1'b0;
      end else if (bus.wr) begin
         // Debug control stays writable while frozen so the halt can be left
         if (bus.addr == oec_pkg::DEBUG_CTRL_OFS) dbg_run_q <= bus.wdata[0];
         if (run && bus.addr == oec_pkg::GLOBAL_CTRL_OFS) glob_en_q <= bus.wdata[0];
         if (run && bus.addr == oec_pkg::TIMEBASE_OFS) timebase_q <= bus.wdata[6:0];
         if (run && bus.addr == oec_pkg::POWER_CTRL_OFS) o_low_range <= bus.wdata[0];
      end
   end

   // Microsecond prescaler shared by all settle timers
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         us_cnt_q <= 7'h00;
      end else if (run) begin
         us_cnt_q <= us_tick ? 7'h00 : us_cnt_q + 7'h01;
      end
   end
   assign us_tick = run & (us_cnt_q >= timebase_q);

   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1) begin : g_ch
         localparam logic [7:0] BASE = 8'(oec_pkg::CHAN_BASE_OFS + c * oec_pkg::CHAN_STRIDE);
         logic       sel;
         logic       restart;
         logic       ev_mode;
         logic       sw_on;
         logic       event_only;
         logic       sleep_off;
         logic       en_pulse;
         logic       dis_pulse;
         logic       ev_on_q;
         logic       on;
         logic       on_q;
         logic [6:0] cnt_q;
         logic       normal;

         assign sel     = bus.addr[7:3] == BASE[7:3];
         assign restart = bus.wr & sel & ((bus.addr[2:0] == oec_pkg::CHAN_CTRL_OFS) |
                          (bus.addr[2:0] == oec_pkg::INPUT_SEL_OFS) |
                          (bus.addr[2:0] == oec_pkg::LADDER_SEL_OFS));

         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               ctrl_q[c]   <= oec_pkg::REG_RESET;
               ladder_q[c] <= oec_pkg::REG_RESET;
               insel_q[c]  <= oec_pkg::REG_RESET;
               settle_q[c] <= 7'h00;
               trim_q[c]   <= oec_pkg::REG_RESET;
            end else if (run && bus.wr && sel) begin
               case (bus.addr[2:0])
                  oec_pkg::CHAN_CTRL_OFS:  ctrl_q[c]   <= bus.wdata;
                  oec_pkg::LADDER_SEL_OFS: ladder_q[c] <= bus.wdata;
                  oec_pkg::INPUT_SEL_OFS:  insel_q[c]  <= bus.wdata;
                  oec_pkg::SETTLE_OFS:     settle_q[c] <= bus.wdata[6:0];
                  oec_pkg::TRIM_OFS:       trim_q[c]   <= bus.wdata;
                  default: ;
               endcase
            end
         end

         assign ev_mode    = ctrl_q[c][oec_pkg::EV_EN_BIT];
         assign sw_on      = ctrl_q[c][oec_pkg::SW_EN_BIT];
         assign event_only = ev_mode & ~sw_on;
         assign sleep_off  = i_standby & ~ctrl_q[c][oec_pkg::STANDBY_BIT];
         assign normal = ctrl_q[c][oec_pkg::OUTPUT_DRIVER_MODE_LSB +: 2] == oec_pkg::OUTPUT_DRIVER_MODE_NORMAL;

         oec_edge_det #(.ASYNC(1'b1)) u_en (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .i_run   (run),
            .i_level (bus.ev_enable[c]),
            .o_pulse (en_pulse)
         );
         oec_edge_det #(.ASYNC(1'b0)) u_dis (
            .i_clk   (i_clk),
            .i_reset (i_reset),
            .i_run   (run),
            .i_level (bus.ev_disable[c]),
            .o_pulse (dis_pulse)
         );

         // Event-driven on/off state; a repeated enable leaves it unchanged
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               ev_on_q <= 1'b0;
            end else if (run) begin
               if (!event_only) begin
                  ev_on_q <= 1'b0;
               end else if (en_pulse) begin
                  ev_on_q <= 1'b1;
               end else if (dis_pulse) begin
                  ev_on_q <= 1'b0;
               end
            end
         end

         assign on = glob_en_q & ~sleep_off & (sw_on | (event_only & ev_on_q));

         // Settle timer counts microseconds from enable or from a restart
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               on_q         <= 1'b0;
               cnt_q        <= 7'h00;
               settle_done_flag_q[c] <= 1'b0;
               ready_q[c]   <= 1'b0;
            end else if (run) begin
               on_q       <= on;
               ready_q[c] <= 1'b0;
               if (!on || !on_q || restart) begin
                  cnt_q        <= 7'h00;
                  settle_done_flag_q[c] <= 1'b0;
               end else if (!settle_done_flag_q[c] && us_tick) begin
                  if (cnt_q >= settle_q[c]) begin
                     settle_done_flag_q[c] <= 1'b1;
                     ready_q[c]   <= event_only;
                  end else begin
                     cnt_q <= cnt_q + 7'h01;
                  end
               end else if (settle_done_flag_q[c] && event_only && en_pulse) begin
                  ready_q[c] <= 1'b1;
               end
            end else begin
               ready_q[c] <= 1'b0;
            end
         end

         // Analog controls keep their last state while the digital side is frozen
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               o_amp_on[c]       <= 1'b0;
               o_drive_en[c]     <= 1'b0;
               o_discharge_sw[c] <= 1'b0;
            end else if (run) begin
               o_amp_on[c]       <= on;
               // Driver off releases the pin to the port logic
               o_drive_en[c]     <= on & (normal | (ev_mode & bus.ev_drive[c]));
               o_discharge_sw[c] <= on & ev_mode & bus.ev_discharge[c];
            end
         end

         assign o_settle_done_flag[c]          = settle_done_flag_q[c];
         assign bus.ev_ready[c]       = ready_q[c];
         assign o_input_sel[c*8 +: 8]   = insel_q[c];
         assign o_ladder_sel[c*8 +: 8]  = ladder_q[c];
         assign o_offset_trim[c*8 +: 8] = trim_q[c];
      end
   endgenerate

   // Read mux; unmapped offsets read zero; status reads the settle flag
   always_comb begin
      rdata_d = 8'h00;
      case (bus.addr)
         oec_pkg::GLOBAL_CTRL_OFS: rdata_d = {7'h00, glob_en_q};
         oec_pkg::DEBUG_CTRL_OFS:  rdata_d = {7'h00, dbg_run_q};
         oec_pkg::TIMEBASE_OFS:    rdata_d = {1'b0, timebase_q};
         oec_pkg::POWER_CTRL_OFS:  rdata_d = {7'h00, o_low_range};
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (bus.addr[7:3] == 5'(({3'h0, oec_pkg::CHAN_BASE_OFS} +
                                         i * oec_pkg::CHAN_STRIDE) >> 3)) begin
                  case (bus.addr[2:0])
                     oec_pkg::CHAN_CTRL_OFS:   rdata_d = ctrl_q[i];
                     oec_pkg::CHAN_STATUS_OFS: rdata_d = {7'h00, settle_done_flag_q[i]};
                     oec_pkg::LADDER_SEL_OFS:  rdata_d = ladder_q[i];
                     oec_pkg::INPUT_SEL_OFS:   rdata_d = insel_q[i];
                     oec_pkg::SETTLE_OFS:      rdata_d = {1'b0, settle_q[i]};
                     oec_pkg::TRIM_OFS:        rdata_d = trim_q[i];
                     default:                  rdata_d = 8'h00;
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// >>> verilog/oec_edge_det.sv
// Rising edge detector with optional two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module oec_edge_det #(
   parameter bit ASYNC = 1'b1
) (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_run,
   input  wire logic i_level,
   output logic      o_pulse
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic samp;

   generate
      if (ASYNC) begin : g_sync
         // Meta flop feeds only the second flop
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= i_level;
               sync_q <= meta_q;
            end
         end
         assign samp = sync_q;
      end else begin : g_direct
         always_comb meta_q = 1'b0;
         always_comb sync_q = 1'b0;
         assign samp = i_level;
      end
   endgenerate

   // prev_q holds while frozen; a level still high when run returns gives its pulse then
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         prev_q <= 1'b0;
      end else if (i_run) begin
         prev_q <= samp;
      end
   end

   assign o_pulse = i_run & samp & ~prev_q;
endmodule
`default_nettype wire

// >>> verilog/oec_host.sv
// Event network and register master: software port, preset orders, trim adjust
`timescale 1ns/1ps
`default_nettype none
module oec_host (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   oec_if.host              bus,
   input  wire logic        i_cmd_valid,
   input  wire logic [3:0]  i_cmd_kind,
   input  wire logic [1:0]  i_cmd_chan,
   input  wire logic [7:0]  i_cmd_arg,
   input  wire logic        i_sw_wr,
   input  wire logic        i_sw_rd,
   input  wire logic [7:0]  i_sw_addr,
   input  wire logic [7:0]  i_sw_wdata,
   input  wire logic [2:0]  i_ev_enable,
   input  wire logic [2:0]  i_ev_disable,
   input  wire logic [2:0]  i_ev_discharge,
   input  wire logic [2:0]  i_ev_drive,
   output logic             o_busy,
   output logic [7:0]       o_rd_data,
   output logic             o_rd_valid,
   output logic [2:0]       o_ready_seen
);
   oec_pkg::oec_host_st_t st_q;
   logic [7:0] a1_q;
   logic [7:0] d1_q;
   logic [7:0] a2_q;
   logic [7:0] d2_q;
   logic [7:0] trim_q [3];
   logic [7:0] base;
   logic [7:0] in_v;
   logic [7:0] lad_v;
   logic       rd_p_q;
   logic       take;

   assign base = 8'(oec_pkg::CHAN_BASE_OFS + {6'h00, i_cmd_chan} * oec_pkg::CHAN_STRIDE);
   assign take = i_cmd_valid & (st_q == oec_pkg::OEC_IDLE);

   // Selection values for each preset configuration
   always_comb begin
      in_v  = 8'h00;
      lad_v = 8'h00;
      case (oec_pkg::oec_cmd_t'(i_cmd_kind))
         oec_pkg::OEC_CFG_FOLLOW: begin
            in_v  = {2'h0, oec_pkg::NEG_OUT, oec_pkg::POS_PIN};
            lad_v = {oec_pkg::LOWEST_TAP, oec_pkg::BOT_OFF, oec_pkg::TOP_OFF};
         end
         oec_pkg::OEC_CFG_PINS: begin
            in_v  = {2'h0, oec_pkg::NEG_PIN, oec_pkg::POS_PIN};
            lad_v = {oec_pkg::LOWEST_TAP, oec_pkg::BOT_OFF, oec_pkg::TOP_OFF};
         end
         oec_pkg::OEC_CFG_NONINV: begin
            in_v  = {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_PIN};
            lad_v = {i_cmd_arg[2:0], oec_pkg::BOT_GND, oec_pkg::TOP_OUT};
         end
         oec_pkg::OEC_CFG_INV: begin
            in_v  = {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_HALF};
            lad_v = {i_cmd_arg[2:0], oec_pkg::BOT_NEG_PIN, oec_pkg::TOP_OUT};
         end
         oec_pkg::OEC_CFG_INTEG: begin
            in_v  = {2'h0, oec_pkg::NEG_PIN, oec_pkg::POS_HALF};
            lad_v = {oec_pkg::LOWEST_TAP, oec_pkg::BOT_OFF, oec_pkg::TOP_OFF};
         end
         oec_pkg::OEC_CFG_DIFF2: begin
            in_v  = {2'h0, oec_pkg::NEG_TAP, oec_pkg::POS_PIN};
            lad_v = {i_cmd_arg[2:0], oec_pkg::BOT_NEIGHBOUR, oec_pkg::TOP_OUT};
         end
         default: ;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_q <= oec_pkg::OEC_IDLE;
         a1_q <= 8'h00;
         d1_q <= 8'h00;
         a2_q <= 8'h00;
         d2_q <= 8'h00;
      end else begin
         case (st_q)
            oec_pkg::OEC_IDLE: begin
               if (take) begin
                  st_q <= oec_pkg::OEC_WR2;
                  a2_q <= base + {5'h00, oec_pkg::CHAN_CTRL_OFS};
                  case (oec_pkg::oec_cmd_t'(i_cmd_kind))
                     // Mode orders keep standby and output mode bits from the argument
                     oec_pkg::OEC_MODE_EVENT: d2_q <= {i_cmd_arg[7:2], 2'h2};
                     oec_pkg::OEC_MODE_SW_EV: d2_q <= {i_cmd_arg[7:2], 2'h3};
                     oec_pkg::OEC_MODE_SW:    d2_q <= {i_cmd_arg[7:2], 2'h1};
                     oec_pkg::OEC_TRIM_ADJ: begin
                        a2_q <= base + {5'h00, oec_pkg::TRIM_OFS};
                        d2_q <= trim_q[i_cmd_chan] + i_cmd_arg;
                     end
                     default: begin
                        st_q <= oec_pkg::OEC_WR1;
                        a1_q <= base + {5'h00, oec_pkg::INPUT_SEL_OFS};
                        d1_q <= in_v;
                        a2_q <= base + {5'h00, oec_pkg::LADDER_SEL_OFS};
                        d2_q <= lad_v;
                     end
                  endcase
               end
            end
            oec_pkg::OEC_WR1: st_q <= oec_pkg::OEC_WR2;
            oec_pkg::OEC_WR2: st_q <= oec_pkg::OEC_IDLE;
            default:          st_q <= oec_pkg::OEC_IDLE;
         endcase
      end
   end

   // Shadow of each trim so an adjustment is relative to the last written value
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < 3; i++) trim_q[i] <= oec_pkg::REG_RESET;
      end else if (st_q == oec_pkg::OEC_WR2 && a2_q[2:0] == oec_pkg::TRIM_OFS) begin
         trim_q[a2_q[4:3] - 2'h2] <= d2_q;
      end else if (i_sw_wr && !take && st_q == oec_pkg::OEC_IDLE &&
                   i_sw_addr[2:0] == oec_pkg::TRIM_OFS && i_sw_addr[7:3] >= 5'h02 &&
                   i_sw_addr[7:3] <= 5'h04) begin
         trim_q[i_sw_addr[4:3] - 2'h2] <= i_sw_wdata;
      end
   end

   // Bus and event outputs; raw software access only while no order runs
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         bus.addr         <= 8'h00;
         bus.wdata        <= 8'h00;
         bus.wr           <= 1'b0;
         bus.rd           <= 1'b0;
         bus.ev_enable    <= 3'h0;
         bus.ev_disable   <= 3'h0;
         bus.ev_discharge <= 3'h0;
         bus.ev_drive     <= 3'h0;
         rd_p_q           <= 1'b0;
         o_rd_valid       <= 1'b0;
         o_rd_data        <= 8'h00;
         o_ready_seen     <= 3'h0;
      end else begin
         bus.wr <= 1'b0;
         bus.rd <= 1'b0;
         if (st_q == oec_pkg::OEC_WR1) begin
            bus.addr  <= a1_q;
            bus.wdata <= d1_q;
            bus.wr    <= 1'b1;
         end else if (st_q == oec_pkg::OEC_WR2) begin
            bus.addr  <= a2_q;
            bus.wdata <= d2_q;
            bus.wr    <= 1'b1;
         end else if (!take && (i_sw_wr || i_sw_rd)) begin
            bus.addr  <= i_sw_addr;
            bus.wdata <= i_sw_wdata;
            bus.wr    <= i_sw_wr;
            bus.rd    <= i_sw_rd & ~i_sw_wr;
         end
         bus.ev_enable    <= i_ev_enable;
         bus.ev_disable   <= i_ev_disable;
         bus.ev_discharge <= i_ev_discharge;
         bus.ev_drive     <= i_ev_drive;
         rd_p_q           <= bus.rd;
         o_rd_valid       <= rd_p_q;
         o_rd_data        <= rd_p_q ? bus.rdata : 8'h00;
         o_ready_seen     <= bus.ev_ready;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= take | (st_q == oec_pkg::OEC_WR1);
      end
   end
endmodule
`default_nettype wire

// >>> verilog/oec_if.sv
// Register bus and event lines between event network master and amplifier control
`timescale 1ns/1ps
`default_nettype none
interface oec_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [2:0] ev_enable;
   logic [2:0] ev_disable;
   logic [2:0] ev_discharge;
   logic [2:0] ev_drive;
   logic [2:0] ev_ready;
   modport dev  (input addr, wdata, wr, rd, ev_enable, ev_disable, ev_discharge, ev_drive,
                 output rdata, ev_ready);
   modport host (output addr, wdata, wr, rd, ev_enable, ev_disable, ev_discharge, ev_drive,
                 input rdata, ev_ready);
endinterface
`default_nettype wire

// >>> verilog/oec_pkg.sv
// Shared constants and types for the amplifier event and sleep control
package oec_pkg;
   localparam int NCH = 3;
   // Byte offsets of the register file
   localparam logic [7:0] GLOBAL_CTRL_OFS  = 8'h00;
   localparam logic [7:0] DEBUG_CTRL_OFS   = 8'h01;
   localparam logic [7:0] TIMEBASE_OFS     = 8'h02;
   localparam logic [7:0] POWER_CTRL_OFS   = 8'h0F;
   localparam logic [7:0] CHAN_BASE_OFS    = 8'h10;
   localparam logic [7:0] CHAN_STRIDE      = 8'h08;
   localparam logic [2:0] CHAN_CTRL_OFS    = 3'h0;
   localparam logic [2:0] CHAN_STATUS_OFS  = 3'h1;
   localparam logic [2:0] LADDER_SEL_OFS   = 3'h2;
   localparam logic [2:0] INPUT_SEL_OFS    = 3'h3;
   localparam logic [2:0] SETTLE_OFS       = 3'h4;
   localparam logic [2:0] TRIM_OFS         = 3'h5;
   // Field positions of channel_control_reg
   localparam int SW_EN_BIT     = 0;
   localparam int EV_EN_BIT     = 1;
   localparam int OUTPUT_DRIVER_MODE_LSB   = 2;
   localparam int STANDBY_BIT   = 7;
   // Field positions of ladder_select_reg and input_select_reg
   localparam int TOP_LSB       = 0;
   localparam int BOT_LSB       = 2;
   localparam int TAP_LSB       = 5;
   localparam int POS_LSB       = 0;
   localparam int NEG_LSB       = 3;
   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field encodings
   localparam logic [1:0] OUTPUT_DRIVER_MODE_NORMAL = 2'h1;
   localparam logic [2:0] POS_PIN        = 3'h0;
   localparam logic [2:0] POS_HALF       = 3'h3;
   localparam logic [2:0] NEG_PIN        = 3'h0;
   localparam logic [2:0] NEG_TAP        = 3'h1;
   localparam logic [2:0] NEG_OUT        = 3'h2;
   localparam logic [2:0] BOT_OFF        = 3'h0;
   localparam logic [2:0] BOT_NEG_PIN    = 3'h2;
   localparam logic [2:0] BOT_GND        = 3'h4;
   localparam logic [2:0] BOT_NEIGHBOUR  = 3'h5;
   localparam logic [1:0] TOP_OFF        = 2'h0;
   localparam logic [1:0] TOP_OUT        = 2'h1;
   localparam logic [2:0] LOWEST_TAP     = 3'h0;
   // Orders the controller accepts
   typedef enum logic [3:0] {
      OEC_MODE_EVENT, OEC_MODE_SW_EV, OEC_MODE_SW, OEC_CFG_FOLLOW, OEC_CFG_PINS,
      OEC_CFG_NONINV, OEC_CFG_INV, OEC_CFG_INTEG, OEC_CFG_DIFF2, OEC_TRIM_ADJ
   } oec_cmd_t;
   typedef enum logic [1:0] {OEC_IDLE, OEC_WR1, OEC_WR2} oec_host_st_t;
endpackage
